// ### pin_state_power_mode_ctrl.sv
// Per-pin drive and input gating across reset and low-power states
// What this block does
// - Analog pin: driver off, input 0, analog on after POR
// - USB pin: float transmit, input 0 receive except in deep standby
// - Listed modes stop main oscillator; sub output pin floats in POR or when sub stops
// - Stop bit 0 holds sub output; 1 stops it in stop and deep standby stop
// - Backup GPIO: POR off, reset 0, prohibited
// - Sub input always enabled; backup RTC holds
// - External sub clock on output pin: POR off, else hold
// - Backup resource pin: POR float, else hold
// - Backup POR means both supplies ramping
// - Hold means state just before mode entry
module pin_state_power_mode_ctrl #(
  parameter int unsigned NUM_PINS = pin_state_pkg::NUM_PINS_DEF
) (
  input wire logic mclk,
  input wire logic srst,
  input wire pin_state_pkg::pwr_state_t pwr_state,
  input wire logic external_reset_in_n,
  input wire logic standby_pin_float_sel,
  input wire logic sub_osc_stop_ctl,
  input wire logic wake_request_input,
  input wire pin_state_pkg::pin_req_t [NUM_PINS-1:0] pin_req,
  output pin_state_pkg::pin_ctl_t [NUM_PINS-1:0] pin_ctl,
  output logic main_osc_run,
  output logic sub_osc_run,
  output logic wake_seen
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;

  // Two-stage capture of asynchronous pins
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_r <= 3'h1;
      sync2_r <= 3'h1;
    end else begin
      sync1_r <= {wake_request_input, standby_pin_float_sel, external_reset_in_n};
      sync2_r <= sync1_r;
    end
  end

  logic ext_rst_n_s;
  logic float_s;
  logic wake_s;
  assign ext_rst_n_s = sync2_r[0];
  assign float_s = sync2_r[1];
  assign wake_s = sync2_r[2];

  // ----------------------------------------
  // State tracking
  // ----------------------------------------
  pin_state_pkg::pwr_state_t state_eff;
  pin_state_pkg::pwr_state_t prev_state_r;
  logic state_change;

  // External reset pin overrides the reported run state
  always_comb begin
    state_eff = pwr_state;
    if (!ext_rst_n_s && pwr_state != pin_state_pkg::ST_POR) begin
      state_eff = pin_state_pkg::ST_EXT_RESET;
    end
  end

  // Previous state register for hold capture
  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_state_r <= pin_state_pkg::ST_POR;
    end else begin
      prev_state_r <= state_eff;
    end
  end

  assign state_change = (state_eff != prev_state_r);

  // Wake input latched while in deep standby
  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_seen <= 1'b0;
    end else if (state_eff == pin_state_pkg::ST_DS_RTC
                 || state_eff == pin_state_pkg::ST_DS_STOP) begin
      wake_seen <= wake_seen | wake_s;
    end else begin
      wake_seen <= 1'b0;
    end
  end

  // ----------------------------------------
  // Oscillator run control
  // ----------------------------------------
  logic osc_stop_state;

  // Modes in which the main oscillator stops
  always_comb begin
    case (state_eff)
      pin_state_pkg::ST_SUB_TIMER,
      pin_state_pkg::ST_LCR_TIMER,
      pin_state_pkg::ST_RTC,
      pin_state_pkg::ST_STOP,
      pin_state_pkg::ST_DS_RTC,
      pin_state_pkg::ST_DS_STOP: osc_stop_state = 1'b1;
      default: osc_stop_state = 1'b0;
    endcase
  end

  // Registered oscillator enables
  always_ff @(posedge mclk) begin
    if (srst) begin
      main_osc_run <= 1'b0;
      sub_osc_run <= 1'b0;
    end else begin
      main_osc_run <= !osc_stop_state;
      // Sub oscillator stops only when the stop bit is set
      sub_osc_run <= !(sub_osc_stop_ctl == pin_state_pkg::OSC_STOP_ENABLE
                       && (state_eff == pin_state_pkg::ST_STOP
                           || state_eff == pin_state_pkg::ST_DS_STOP));
    end
  end

  // ----------------------------------------
  // Per-pin selection
  // ----------------------------------------
  pin_state_pkg::pin_ctl_t [NUM_PINS-1:0] live_ctl;
  pin_state_pkg::pin_ctl_t [NUM_PINS-1:0] held_ctl;
  pin_state_pkg::pin_ctl_t [NUM_PINS-1:0] sel_ctl;
  logic [NUM_PINS-1:0] capture;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      // Control the pin would show if it followed its function live
      always_comb begin
        live_ctl[g] = '0;
        live_ctl[g].oe = pin_req[g].drive_en;
        live_ctl[g].dout = pin_req[g].drive_val;
        live_ctl[g].in_en = 1'b1;
      end

      // Capture in the first cycle after leaving run/sleep, while the request is still live
      assign capture[g] = state_change && prev_state_r == pin_state_pkg::ST_RUN_SLEEP;

      // Selection by state, float bit and function
      always_comb begin
        sel_ctl[g] = '0;
        case (pin_req[g].func)
          pin_state_pkg::FN_ANALOG: begin
            // Float in POR, analog path on afterwards
            sel_ctl[g].ana_en = (state_eff != pin_state_pkg::ST_POR);
          end
          pin_state_pkg::FN_USB: begin
            case (state_eff)
              pin_state_pkg::ST_RUN_SLEEP, pin_state_pkg::ST_TIMER,
              pin_state_pkg::ST_SUB_TIMER, pin_state_pkg::ST_LCR_TIMER,
              pin_state_pkg::ST_RTC, pin_state_pkg::ST_STOP: begin
                sel_ctl[g].in_en = 1'b0;
              end
              pin_state_pkg::ST_DS_RTC, pin_state_pkg::ST_DS_STOP,
              pin_state_pkg::ST_DS_RETURN: sel_ctl[g].in_en = 1'b1;
              default: sel_ctl[g] = '0;
            endcase
          end
          pin_state_pkg::FN_GPIO: begin
            case (state_eff)
              pin_state_pkg::ST_POR, pin_state_pkg::ST_EXT_RESET,
              pin_state_pkg::ST_INT_RESET: sel_ctl[g] = '0;
              pin_state_pkg::ST_RUN_SLEEP: sel_ctl[g] = live_ctl[g];
              pin_state_pkg::ST_DS_RTC, pin_state_pkg::ST_DS_STOP: begin
                sel_ctl[g] = (float_s == pin_state_pkg::PIN_FLOAT) ? '0 : held_ctl[g];
              end
              default: sel_ctl[g] = held_ctl[g];
            endcase
          end
          pin_state_pkg::FN_BK_GPIO: begin
            case (state_eff)
              pin_state_pkg::ST_POR: sel_ctl[g] = '0;
              pin_state_pkg::ST_EXT_RESET,
              pin_state_pkg::ST_INT_RESET: sel_ctl[g].in_en = 1'b0;
              pin_state_pkg::ST_BK_RTC: sel_ctl[g].prohibited = 1'b1;
              pin_state_pkg::ST_BK_RETURN: sel_ctl[g] = held_ctl[g];
              default: sel_ctl[g] = live_ctl[g];
            endcase
          end
          pin_state_pkg::FN_SUB_IN: begin
            sel_ctl[g].in_en = 1'b1;
            if (state_eff == pin_state_pkg::ST_BK_RTC
                || state_eff == pin_state_pkg::ST_BK_RETURN) begin
              sel_ctl[g] = held_ctl[g];
              sel_ctl[g].in_en = 1'b1;
            end
          end
          pin_state_pkg::FN_SUB_EXT_OUT: begin
            // Disabled in POR, retained elsewhere
            sel_ctl[g] = (state_eff == pin_state_pkg::ST_POR) ? '0 : held_ctl[g];
          end
          pin_state_pkg::FN_SUB_XOUT: begin
            if (state_eff == pin_state_pkg::ST_POR) begin
              sel_ctl[g] = '0;
            end else if (!sub_osc_run) begin
              sel_ctl[g] = '0;
            end else begin
              sel_ctl[g] = held_ctl[g];
            end
          end
          pin_state_pkg::FN_BK_RES: begin
            sel_ctl[g] = (state_eff == pin_state_pkg::ST_POR) ? '0 : held_ctl[g];
          end
          default: sel_ctl[g] = '0;
        endcase
      end

      // Registered pad control
      always_ff @(posedge mclk) begin
        if (srst) begin
          pin_ctl[g] <= '0;
        end else begin
          pin_ctl[g] <= sel_ctl[g];
        end
      end

      // Analog pins never drive nor pass digital input
      a_analog_gate: assert property (@(posedge mclk) disable iff (srst)
        pin_req[g].func == pin_state_pkg::FN_ANALOG |=> !pin_ctl[g].oe && !pin_ctl[g].in_en)
        else $error("analog pin driven or input open");

      // USB receive input forced low in run/sleep
      a_usb_rx_gate: assert property (@(posedge mclk) disable iff (srst)
        pin_req[g].func == pin_state_pkg::FN_USB
        && state_eff == pin_state_pkg::ST_RUN_SLEEP |=> !pin_ctl[g].in_en && !pin_ctl[g].oe)
        else $error("usb pin not gated in run");

      // Backup GPIO prohibited in backup RTC
      a_bk_prohibit: assert property (@(posedge mclk) disable iff (srst)
        pin_req[g].func == pin_state_pkg::FN_BK_GPIO
        && state_eff == pin_state_pkg::ST_BK_RTC |=> pin_ctl[g].prohibited)
        else $error("backup gpio not flagged prohibited");

      // Sub input stays enabled
      a_sub_in_on: assert property (@(posedge mclk) disable iff (srst)
        pin_req[g].func == pin_state_pkg::FN_SUB_IN |=> pin_ctl[g].in_en)
        else $error("sub clock input gated");

      // External sub clock on output position disabled in POR
      a_ext_out_por: assert property (@(posedge mclk) disable iff (srst)
        pin_req[g].func == pin_state_pkg::FN_SUB_EXT_OUT
        && state_eff == pin_state_pkg::ST_POR |=> pin_ctl[g] == '0)
        else $error("external sub clock pin active in reset");

      // Backup resource pin floats in POR
      a_bk_res_por: assert property (@(posedge mclk) disable iff (srst)
        pin_req[g].func == pin_state_pkg::FN_BK_RES
        && state_eff == pin_state_pkg::ST_POR |=> !pin_ctl[g].oe)
        else $error("backup resource pin driven in reset");

      // Hold follows the value before the change
      a_hold_value: assert property (@(posedge mclk) disable iff (srst)
        pin_req[g].func == pin_state_pkg::FN_BK_RES && state_eff != pin_state_pkg::ST_POR
        && $stable(held_ctl[g]) ##1 $stable(held_ctl[g]) |-> pin_ctl[g] == $past(held_ctl[g]))
        else $error("backup resource pin not holding");
    end
  endgenerate

  // Retention storage
  pin_hold_reg #(
    .NUM_PINS(NUM_PINS)
  ) u_hold (
    .mclk(mclk),
    .srst(srst),
    .capture(capture),
    .ctl_in(live_ctl),
    .ctl_held(held_ctl)
  );

  // ----------------------------------------
  // Oscillator checks
  // ----------------------------------------
  a_main_osc_stop: assert property (@(posedge mclk) disable iff (srst)
    state_eff == pin_state_pkg::ST_RTC |=> !main_osc_run)
    else $error("main oscillator running in rtc mode");

  a_sub_osc_keep: assert property (@(posedge mclk) disable iff (srst)
    !sub_osc_stop_ctl |=> sub_osc_run)
    else $error("sub oscillator stopped with stop bit clear");

endmodule // pin_state_power_mode_ctrl

// ### pin_state_pkg.sv
// Shared types and constants for the per-pin power-state selection logic
package pin_state_pkg;

  // ----------------------------------------
  // Power states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_POR,          // Power-on reset, both supplies ramping
    ST_EXT_RESET,    // External reset input held low
    ST_INT_RESET,    // Device internal reset
    ST_RUN_SLEEP,    // Run or sleep
    ST_TIMER,        // Main / PLL / high-speed timer mode
    ST_SUB_TIMER,    // Sub timer mode
    ST_LCR_TIMER,    // Low-speed internal oscillator timer mode
    ST_RTC,          // RTC mode
    ST_STOP,         // Stop mode
    ST_DS_RTC,       // Deep standby RTC
    ST_DS_STOP,      // Deep standby stop
    ST_DS_RETURN,    // Return from deep standby
    ST_BK_RTC,       // Backup-domain RTC mode
    ST_BK_RETURN     // Return from backup-domain RTC mode
  } pwr_state_t;

  // ----------------------------------------
  // Pin functions
  // ----------------------------------------
  typedef enum logic [2:0] {
    FN_GPIO,         // Main-domain general-purpose I/O
    FN_ANALOG,       // Analog input
    FN_USB,          // USB I/O
    FN_BK_GPIO,      // Backup-domain general-purpose I/O
    FN_SUB_IN,       // Sub crystal input / external sub clock input
    FN_SUB_EXT_OUT,  // External sub clock on sub-oscillator output position
    FN_SUB_XOUT,     // Sub crystal oscillator output
    FN_BK_RES        // Backup-domain resource or GPIO pin type
  } pin_func_t;

  // Per-pin request from the peripheral / port side
  typedef struct packed {
    pin_func_t func;
    logic drive_en;   // Peripheral or port wants to drive
    logic drive_val;  // Value to drive
    logic usb_tx;     // USB transceiver transmitting
  } pin_req_t;

  // Per-pin control toward the pad
  typedef struct packed {
    logic oe;         // Driver enable
    logic dout;       // Driven value
    logic in_en;      // Digital input gate open
    logic ana_en;     // Analog path enabled
    logic prohibited; // Setting prohibited in this state
  } pin_ctl_t;

  localparam int unsigned NUM_PINS_DEF = 8;
  localparam logic OSC_STOP_ENABLE = 1'h1;
  localparam logic PIN_FLOAT = 1'h1;

endpackage : pin_state_pkg

// ### pin_hold_reg.sv
// Retention register holding each pin's last control before leaving run/sleep
module pin_hold_reg #(
  parameter int unsigned NUM_PINS = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [NUM_PINS-1:0] capture,
  input wire pin_state_pkg::pin_ctl_t [NUM_PINS-1:0] ctl_in,
  output pin_state_pkg::pin_ctl_t [NUM_PINS-1:0] ctl_held
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  pin_state_pkg::pin_ctl_t [NUM_PINS-1:0] held_r;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      // Per-pin capture, cleared to a safe floating input on reset
      always_ff @(posedge mclk) begin
        if (srst) begin
          held_r[g] <= '0;
        end else if (capture[g]) begin
          held_r[g] <= ctl_in[g];
        end
      end
    end
  endgenerate

  assign ctl_held = held_r;

endmodule // pin_hold_reg

// ### pin_state_power_mode_ctrl_tb_top.sv
// Self-checking bench for the per-pin power-state selection block
module pin_state_power_mode_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned NP = 4;
  typedef struct packed {
    pin_state_pkg::pwr_state_t st;
    pin_state_pkg::pin_func_t fn;
    logic tx;
    logic stop;
    logic [4:0] ex;
    logic [4:0] mk;
    logic [1:0] ox;
    logic [1:0] om;
  } row_t;
  logic mclk;
  logic srst;
  logic ext_n;
  logic float_sel;
  logic stop_bit;
  logic wake;
  pin_state_pkg::pwr_state_t st;
  pin_state_pkg::pin_req_t [NP-1:0] req;
  pin_state_pkg::pin_ctl_t [NP-1:0] ctl;
  logic main_run;
  logic sub_run;
  logic wake_seen;
  row_t rows[$];
  int n_fail;
  int checked;
  int cyc;

  pin_state_power_mode_ctrl #(.NUM_PINS(NP)) dut_u (
    .mclk(mclk),
    .srst(srst),
    .pwr_state(st),
    .external_reset_in_n(ext_n),
    .standby_pin_float_sel(float_sel),
    .sub_osc_stop_ctl(stop_bit),
    .wake_request_input(wake),
    .pin_req(req),
    .pin_ctl(ctl),
    .main_osc_run(main_run),
    .sub_osc_run(sub_run),
    .wake_seen(wake_seen)
  );

  // --------------------------------
  // Clock and cycle ceiling
  // --------------------------------
  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // Cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("BAD t=%0t timeout", $time);
      results();
    end
  end

  // --------------------------------
  // Tasks
  // --------------------------------
  // Masked compare of a control or oscillator vector
  task automatic chk(input logic [4:0] got, input logic [4:0] ex, input logic [4:0] mk);
    checked++;
    if ((got & mk) !== (ex & mk)) begin
      n_fail++;
      $display("BAD t=%0t got %b exp %b mask %b", $time, got, ex, mk);
    end
  endtask

  // Same request on every pin, driven at the edge
  task automatic set_req(input pin_state_pkg::pin_func_t fn, input logic de, input logic dv,
                         input logic tx);
    for (int i = 0; i < NP; i++) begin
      req[i] <= '{func: fn, drive_en: de, drive_val: dv, usb_tx: tx};
    end
  endtask

  // Lets n edges pass, then samples just after the last
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic add(input int s, input pin_state_pkg::pin_func_t fn, input logic tx,
                     input logic stop, input logic [4:0] ex, input logic [4:0] mk,
                     input logic [1:0] ox, input logic [1:0] om);
    rows.push_back('{pin_state_pkg::pwr_state_t'(s), fn, tx, stop, ex, mk, ox, om});
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    srst = 1'h1;
    ext_n = 1'h1;
    float_sel = 1'h0;
    stop_bit = 1'h0;
    wake = 1'h0;
    st = pin_state_pkg::ST_POR;
    req = '0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    // Table of ordinary cases
    add(0, pin_state_pkg::FN_ANALOG, 0, 0, 5'h00, 5'h12, 2'h0, 2'h0);
    for (int s = 1; s < 14; s++) begin
      add(s, pin_state_pkg::FN_ANALOG, 0, 0, 5'h02, 5'h16, 2'h0, 2'h0);
    end
    for (int s = 3; s < 9; s++) begin
      add(s, pin_state_pkg::FN_USB, 1, 0, 5'h00, 5'h10, 2'h0, 2'h0);
      add(s, pin_state_pkg::FN_USB, 0, 0, 5'h00, 5'h04, 2'h0, 2'h0);
    end
    for (int s = 5; s < 11; s++) begin
      add(s, pin_state_pkg::FN_GPIO, 0, 0, 5'h00, 5'h00, 2'h0, 2'h2);
    end
    add(3, pin_state_pkg::FN_GPIO, 0, 0, 5'h00, 5'h00, 2'h2, 2'h2);
    add(4, pin_state_pkg::FN_GPIO, 0, 0, 5'h00, 5'h00, 2'h2, 2'h2);
    add(8, pin_state_pkg::FN_SUB_XOUT, 0, 1, 5'h00, 5'h10, 2'h0, 2'h1);
    add(10, pin_state_pkg::FN_SUB_XOUT, 0, 1, 5'h00, 5'h10, 2'h0, 2'h1);
    add(8, pin_state_pkg::FN_SUB_XOUT, 0, 0, 5'h00, 5'h00, 2'h1, 2'h1);
    add(7, pin_state_pkg::FN_SUB_XOUT, 0, 1, 5'h00, 5'h00, 2'h1, 2'h1);
    add(0, pin_state_pkg::FN_BK_GPIO, 0, 0, 5'h00, 5'h14, 2'h0, 2'h0);
    add(1, pin_state_pkg::FN_BK_GPIO, 0, 0, 5'h00, 5'h04, 2'h0, 2'h0);
    add(2, pin_state_pkg::FN_BK_GPIO, 0, 0, 5'h00, 5'h04, 2'h0, 2'h0);
    for (int s = 3; s < 12; s++) begin
      add(s, pin_state_pkg::FN_BK_GPIO, 0, 0, 5'h04, 5'h04, 2'h0, 2'h0);
    end
    add(12, pin_state_pkg::FN_BK_GPIO, 0, 0, 5'h01, 5'h1F, 2'h0, 2'h0);
    for (int s = 0; s < 12; s++) begin
      add(s, pin_state_pkg::FN_SUB_IN, 0, 0, 5'h04, 5'h04, 2'h0, 2'h0);
    end
    add(0, pin_state_pkg::FN_SUB_EXT_OUT, 0, 0, 5'h00, 5'h10, 2'h0, 2'h0);
    add(0, pin_state_pkg::FN_BK_RES, 0, 0, 5'h00, 5'h10, 2'h0, 2'h0);
    add(3, pin_state_pkg::FN_BK_RES, 0, 0, 5'h00, 5'h10, 2'h0, 2'h0);
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    settle(2);
    foreach (rows[i]) begin
      @(posedge mclk);
      st <= rows[i].st;
      stop_bit <= rows[i].stop;
      set_req(rows[i].fn, 1'h0, 1'h0, rows[i].tx);
      settle(3);
      chk(ctl[0], rows[i].ex, rows[i].mk);
      chk(ctl[NP-1], rows[i].ex, rows[i].mk);
      chk({3'h0, main_run, sub_run}, {3'h0, rows[i].ox}, {3'h0, rows[i].om});
    end
    // Port output kept when leaving run while the request changes
    @(posedge mclk);
    st <= pin_state_pkg::ST_RUN_SLEEP;
    set_req(pin_state_pkg::FN_GPIO, 1'h1, 1'h1, 1'h0);
    settle(4);
    chk(ctl[0], 5'h18, 5'h18);
    @(posedge mclk);
    st <= pin_state_pkg::ST_TIMER;
    @(posedge mclk);
    set_req(pin_state_pkg::FN_GPIO, 1'h1, 1'h0, 1'h0);
    settle(3);
    chk(ctl[0], 5'h18, 5'h18);
    // External reset pin gates backup port input, then releases it
    @(posedge mclk);
    st <= pin_state_pkg::ST_RUN_SLEEP;
    set_req(pin_state_pkg::FN_BK_GPIO, 1'h0, 1'h0, 1'h0);
    settle(4);
    chk(ctl[0], 5'h04, 5'h04);
    @(posedge mclk);
    ext_n <= 1'h0;
    settle(5);
    chk(ctl[0], 5'h00, 5'h04);
    @(posedge mclk);
    ext_n <= 1'h1;
    settle(5);
    chk(ctl[0], 5'h04, 5'h04);
    // Deep standby keeps port output, float bit releases it, wake is latched
    @(posedge mclk);
    set_req(pin_state_pkg::FN_GPIO, 1'h1, 1'h1, 1'h0);
    settle(3);
    @(posedge mclk);
    st <= pin_state_pkg::ST_DS_RTC;
    settle(3);
    chk(ctl[0], 5'h18, 5'h18);
    @(posedge mclk);
    wake <= 1'h1;
    settle(4);
    chk({4'h0, wake_seen}, 5'h01, 5'h01);
    @(posedge mclk);
    wake <= 1'h0;
    float_sel <= 1'h1;
    settle(4);
    chk({4'h0, wake_seen}, 5'h01, 5'h01);
    chk(ctl[0], 5'h00, 5'h18);
    @(posedge mclk);
    st <= pin_state_pkg::ST_RUN_SLEEP;
    settle(3);
    chk({4'h0, wake_seen}, 5'h00, 5'h01);
    chk(ctl[0], 5'h1C, 5'h1C);
    // Reset in mid-run clears pin 0 control and both oscillator enables
    @(posedge mclk);
    srst <= 1'h1;
    settle(2);
    chk(ctl[0], 5'h00, 5'h1F);
    chk({3'h0, main_run, sub_run}, 5'h00, 5'h03);
    @(posedge mclk);
    srst <= 1'h0;
    settle(2);
    chk(ctl[0], 5'h1C, 5'h1C);
    chk({3'h0, main_run, sub_run}, 5'h03, 5'h03);
    results();
  end
endmodule // pin_state_power_mode_ctrl_tb_top
